/* rtl/wwdt_map.vh */
/*
  Constants for the windowed watchdog: register indices, field positions,
  reset values and timing counts.
  Assumes it is included by bare name from the watchdog design files.
*/
`ifndef WWDT_MAP_VH
`define WWDT_MAP_VH

// Register indices (byte address is four times the index)
`define WWDT_IDX_CTRL        1'h0
`define WWDT_IDX_STATUS      1'h1

// control_reg_a fields
`define WWDT_CTRL_OPEN_LSB   0
`define WWDT_CTRL_OPEN_MSB   3
`define WWDT_CTRL_CLOSED_LSB 4
`define WWDT_CTRL_CLOSED_MSB 7

// Status fields
`define WWDT_STAT_PEND_BIT   0
`define WWDT_STAT_LOCK_BIT   7

// Reset values
`define WWDT_STATUS_RST      8'h00
`define WWDT_CTRL_RST        8'h00

// Length codes
`define WWDT_CODE_OFF        4'h0
`define WWDT_CODE_MAX        4'hB
`define WWDT_LEN_BASE        14'h0008
`define WWDT_LEN_TOP         14'h2000

// Timing counts
`define WWDT_UNLOCK_CYCLES   3'h4
`define WWDT_SYNC_TICKS      2'h2

`endif

/* rtl/wwdt_sync3.v */
/*
  Three-stage synchroniser with agreement filter and rising-edge pulse.
  Assumes an asynchronous level input and one system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wwdt_sync3 (
  input  wire clk_in,
  input  wire arst_n_in,
  input  wire async_in,
  output reg  level_out,
  output reg  rise_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      level_out <= 1'b0;
      rise_out  <= 1'b0;
    end else begin
      s1_q     <= async_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      rise_out <= 1'b0;
      // Only an agreed value counts, so a metastable sample never toggles
      if (s2_q == s3_q) begin
        level_out <= s3_q;
        rise_out  <= s3_q & ~level_out;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/wwdt_top.v */
/*
  Windowed watchdog timer with Avalon-MM register slave, change-protect
  unlock, a lock cleared only by a status write during debug halt, fuse boot defaults and a held system reset request.
  Assumes a 20 MHz system clock, a free-running 1.024 kHz tick pin from the
  low-power oscillator, and core-side strobes on the system clock.
*/
// Implementation choices: the Avalon-MM slave port and the address map.
`include "wwdt_map.vh"
`timescale 1ns/100ps
`default_nettype none
module wwdt_top (
  input  wire        SYS_CLK_IN,
  input  wire        ARST_N_IN,
  input  wire        TICK_CLOCK_IN,
  input  wire [7:0]  BOOT_FUSE_CONFIG_IN,
  input  wire        COUNTER_CLEAR_INSTR_IN,
  input  wire        CHANGE_PROTECT_UNLOCK_IN,
  input  wire        DEBUG_HALT_IN,
  input  wire [1:0]  AVS_ADDRESS_IN,
  input  wire        AVS_READ_IN,
  input  wire        AVS_WRITE_IN,
  input  wire [31:0] AVS_WRITEDATA_IN,
  input  wire [3:0]  AVS_BYTEENABLE_IN,
  output reg  [31:0] AVS_READDATA_OUT,
  output reg         AVS_WAITREQUEST_OUT,
  output reg         SYS_RESET_REQ_OUT
);
  // One-hot states; FIRED is left only by device reset
  localparam [5:0] ST_OFF    = 6'h01;
  localparam [5:0] ST_NORMAL = 6'h02;
  localparam [5:0] ST_FIRST  = 6'h04;
  localparam [5:0] ST_CLOSED = 6'h08;
  localparam [5:0] ST_OPEN   = 6'h10;
  localparam [5:0] ST_FIRED  = 6'h20;

  // Code to tick count; reserved codes take the longest length
  function [13:0] len_of;
    input [3:0] code;
    begin
      if (code == `WWDT_CODE_OFF || code > `WWDT_CODE_MAX)
        len_of = `WWDT_LEN_TOP;
      else
        len_of = `WWDT_LEN_BASE << (code - 4'h1);
    end
  endfunction

  function [5:0] start_state;
    input [3:0] open_code;
    input [3:0] closed_code;
    begin
      if (open_code == `WWDT_CODE_OFF)
        start_state = ST_OFF;
      else if (closed_code == `WWDT_CODE_OFF)
        start_state = ST_NORMAL;
      else
        start_state = ST_FIRST;
    end
  endfunction

  // Register select, shared by the write strobes and the read mux
  function is_reg;
    input [1:0] addr;
    input       idx;
    begin
      is_reg = (addr == {1'b0, idx});
    end
  endfunction

  wire tick_en;

  reg        boot_q;
  reg  [7:0] ctrl_q;
  reg  [7:0] ctrl_d;
  reg        lock_q;
  reg        lock_d;
  reg  [2:0] unlock_q;
  reg  [2:0] unlock_d;
  reg        pend_q;
  reg        pend_d;
  reg  [1:0] sync_q;
  reg  [1:0] sync_d;
  reg  [7:0] act_q;
  reg  [7:0] act_d;
  reg  [5:0] st_q;
  reg  [5:0] st_d;
  reg [13:0] cnt_q;
  reg [13:0] cnt_d;
  reg        clr_q;
  reg        clr_d;
  reg        rst_d;
  reg        wait_d;
  reg [31:0] rdata_d;

  wire [3:0]  act_open   = act_q[`WWDT_CTRL_OPEN_MSB:`WWDT_CTRL_OPEN_LSB];
  wire [3:0]  act_closed = act_q[`WWDT_CTRL_CLOSED_MSB:`WWDT_CTRL_CLOSED_LSB];
  wire [13:0] open_last   = len_of(act_open) - 14'h0001;
  wire [13:0] closed_last = len_of(act_closed) - 14'h0001;

  wire bus_req = AVS_READ_IN | AVS_WRITE_IN;
  wire bus_acc = bus_req & ~AVS_WAITREQUEST_OUT;
  wire wr_acc  = bus_acc & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
  // Writes count only on the accept edge, byte lane 0
  wire wr_ctrl = wr_acc & is_reg(AVS_ADDRESS_IN, `WWDT_IDX_CTRL);
  wire wr_stat = wr_acc & is_reg(AVS_ADDRESS_IN, `WWDT_IDX_STATUS);
  wire unlocked = (unlock_q != 3'h0);

  // Oscillator tick is asynchronous; only its synchronised rise counts
  wwdt_sync3 u_tick (
    .clk_in    (SYS_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .async_in  (TICK_CLOCK_IN),
    .level_out (),
    .rise_out  (tick_en)
  );

  // Register side: unlock window, lock, control, crossing of writes
  always @* begin
    ctrl_d   = ctrl_q;
    lock_d   = lock_q;
    unlock_d = unlock_q;
    pend_d   = pend_q;
    sync_d   = sync_q;
    act_d    = act_q;

    // Unlock window runs down one cycle at a time
    if (unlock_q != 3'h0)
      unlock_d = unlock_q - 3'h1;
    if (CHANGE_PROTECT_UNLOCK_IN)
      unlock_d = `WWDT_UNLOCK_CYCLES;

    // Fuse matters only on the first edge after reset
    if (boot_q) begin
      ctrl_d = BOOT_FUSE_CONFIG_IN;
      act_d  = BOOT_FUSE_CONFIG_IN;
      lock_d = (BOOT_FUSE_CONFIG_IN[`WWDT_CTRL_OPEN_MSB:`WWDT_CTRL_OPEN_LSB] != `WWDT_CODE_OFF);
    end else begin
      // Locked, still-crossing or unprotected control writes are dropped silently; status writes need only the unlock
      if (wr_ctrl && unlocked && !lock_q && !pend_q) begin
        ctrl_d   = AVS_WRITEDATA_IN[7:0];
        pend_d   = 1'b1;
        sync_d   = 2'h0;
        unlock_d = 3'h0;
      end
      if (wr_stat && unlocked) begin
        unlock_d = 3'h0;
        if (AVS_WRITEDATA_IN[`WWDT_STAT_LOCK_BIT])
          lock_d = 1'b1;
        else if (DEBUG_HALT_IN)
          lock_d = 1'b0;
      end

      // Two tick edges settle the value before timing uses it
      if (pend_q && tick_en) begin
        if (sync_q == `WWDT_SYNC_TICKS - 2'h1) begin
          pend_d = 1'b0;
          act_d  = ctrl_q;
        end else begin
          sync_d = sync_q + 2'h1;
        end
      end
    end
  end

  // Timer side, advanced only on tick enables
  always @* begin
    st_d  = st_q;
    cnt_d = cnt_q;
    clr_d = clr_q;
    rst_d = SYS_RESET_REQ_OUT;
    // Clear waits for the next tick, like the core-to-tick crossing
    if (COUNTER_CLEAR_INSTR_IN)
      clr_d = 1'b1;
    if (st_q == ST_FIRED) begin
      rst_d = 1'b1;
    end else if (boot_q || DEBUG_HALT_IN || (pend_q && tick_en && pend_d == 1'b0)) begin
      // Halt or new settings restart timing from scratch
      st_d  = start_state(boot_q ? BOOT_FUSE_CONFIG_IN[3:0] : act_d[3:0],
                          boot_q ? BOOT_FUSE_CONFIG_IN[7:4] : act_d[7:4]);
      cnt_d = 14'h0000;
      clr_d = 1'b0;
    end else if (tick_en) begin
      // A clear arriving in this cycle is kept for the next tick
      clr_d = COUNTER_CLEAR_INSTR_IN;
      cnt_d = cnt_q + 14'h0001;

      // Every tick outside OFF ages the count; a pending clear acts first
      case (st_q)
        ST_OFF: begin
          cnt_d = 14'h0000;
        end
        ST_NORMAL, ST_FIRST: begin
          if (clr_q) begin
            cnt_d = 14'h0000;
            if (st_q == ST_FIRST)
              st_d = ST_CLOSED;
          end else if (cnt_q == open_last) begin
            st_d = ST_FIRED;
          end
        end
        ST_CLOSED: begin
          if (clr_q) begin
            st_d = ST_FIRED;
          end else if (cnt_q == closed_last) begin
            st_d  = ST_OPEN;
            cnt_d = 14'h0000;
          end
        end
        ST_OPEN: begin
          if (clr_q) begin
            st_d  = ST_CLOSED;
            cnt_d = 14'h0000;
          end else if (cnt_q == open_last) begin
            st_d = ST_FIRED;
          end
        end
        default: begin
          st_d  = ST_OFF;
          cnt_d = 14'h0000;
        end
      endcase
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge
  always @* begin
    wait_d  = 1'b1;
    rdata_d = 32'h00000000;
    if (bus_req && AVS_WAITREQUEST_OUT) begin
      wait_d = 1'b0;
      if (is_reg(AVS_ADDRESS_IN, `WWDT_IDX_CTRL))
        rdata_d = {24'h000000, ctrl_q};
      else if (is_reg(AVS_ADDRESS_IN, `WWDT_IDX_STATUS))
        rdata_d = {24'h000000, lock_q, 6'h00, pend_q};
    end
  end

  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      boot_q              <= 1'b1;
      ctrl_q              <= `WWDT_CTRL_RST;
      lock_q              <= 1'b0;
      unlock_q            <= 3'h0;
      pend_q              <= 1'b0;
      sync_q              <= 2'h0;
      act_q               <= `WWDT_CTRL_RST;
      st_q                <= ST_OFF;
      cnt_q               <= 14'h0000;
      clr_q               <= 1'b0;
      SYS_RESET_REQ_OUT   <= 1'b0;
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h00000000;
    end else begin
      boot_q              <= 1'b0;
      ctrl_q              <= ctrl_d;
      lock_q              <= lock_d;
      unlock_q            <= unlock_d;
      pend_q              <= pend_d;
      sync_q              <= sync_d;
      act_q               <= act_d;
      st_q                <= st_d;
      cnt_q               <= cnt_d;
      clr_q               <= clr_d;
      SYS_RESET_REQ_OUT   <= rst_d | (st_d == ST_FIRED);
      AVS_WAITREQUEST_OUT <= wait_d;

      // Read data held between accesses
      if (!wait_d)
        AVS_READDATA_OUT <= rdata_d;
    end
  end
endmodule
`default_nettype wire

/* dv/wwdt_chk.sv */
/*
  Port checker for the windowed watchdog, bound to its top module.
  Assumes the tick input stays high for eight clock cycles per period.
*/
`timescale 1ns/100ps
`default_nettype none
module wwdt_chk (
  input wire        SYS_CLK_IN,
  input wire        ARST_N_IN,
  input wire        TICK_CLOCK_IN,
  input wire        DEBUG_HALT_IN,
  input wire [1:0]  AVS_ADDRESS_IN,
  input wire        AVS_READ_IN,
  input wire        AVS_WRITE_IN,
  input wire [31:0] AVS_READDATA_OUT,
  input wire        AVS_WAITREQUEST_OUT,
  input wire        SYS_RESET_REQ_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire req = AVS_READ_IN | AVS_WRITE_IN;

  wait_one_a: assert property (req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("access not answered after one wait");
  wait_pulse_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("wait low longer than one cycle");
  rd_unmap_a: assert property (AVS_READ_IN && AVS_ADDRESS_IN[1] && !AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!req && AVS_WAITREQUEST_OUT |=> $stable(AVS_READDATA_OUT))
    else $error("read data moved while idle");
  req_held_a: assert property (SYS_RESET_REQ_OUT |=> SYS_RESET_REQ_OUT)
    else $error("reset request dropped");
  req_boot_a: assert property (ARST_N_IN && !$past(ARST_N_IN) |-> !SYS_RESET_REQ_OUT)
    else $error("reset request survived reset");
  // Firing only follows a tick edge, so tick is still high then
  req_tick_a: assert property ($rose(SYS_RESET_REQ_OUT) |-> TICK_CLOCK_IN)
    else $error("reset request off tick timing");
  dbg_quiet_a: assert property (DEBUG_HALT_IN [*4] |=> !$rose(SYS_RESET_REQ_OUT))
    else $error("reset request during debug halt");

  cover property ($rose(SYS_RESET_REQ_OUT));
  cover property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT);
  cover property (DEBUG_HALT_IN [*4]);
endmodule
bind wwdt_top wwdt_chk chk (.SYS_CLK_IN, .ARST_N_IN, .TICK_CLOCK_IN, .DEBUG_HALT_IN, .AVS_ADDRESS_IN,
  .AVS_READ_IN, .AVS_WRITE_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .SYS_RESET_REQ_OUT);
`default_nettype wire

/* dv/wwdt_core_model.sv */
/*
  Core-side model: bus master, clear strobe and unlock key.
  Assumes the slave answers by waitrequest low, however late.
*/
`timescale 1ns/100ps
`default_nettype none
module wwdt_core_model (
  input  wire             clk_in,
  input  wire [31:0]      rdata_in,
  input  wire             wait_in,
  output var logic [1:0]  addr_out  = 2'h0,
  output var logic        rd_out    = 1'b0,
  output var logic        wr_out    = 1'b0,
  output var logic [31:0] wdata_out = 32'h0,
  output var logic [3:0]  be_out    = 4'h1,
  output var logic        clr_out   = 1'b0,
  output var logic        unl_out   = 1'b0
);
  task automatic xfer(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    addr_out  <= a;
    rd_out    <= !w;
    wr_out    <= w;
    wdata_out <= {24'h0, d};
    do @(posedge clk_in); while (wait_in !== 1'b0);
    q = rdata_in[7:0];
    rd_out <= 1'b0;
    wr_out <= 1'b0;
  endtask

  // Control writes wait out a crossing in flight
  task automatic prot(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] s;
    s = 8'h01;
    while (a == 2'h0 && s[0] !== 1'b0) xfer(1'b0, 2'h1, 8'h00, s);
    @(posedge clk_in);
    unl_out <= 1'b1;
    @(posedge clk_in);
    unl_out <= 1'b0;
    xfer(1'b1, a, d, s);
  endtask

  task automatic clear();
    @(posedge clk_in);
    clr_out <= 1'b1;
    @(posedge clk_in);
    clr_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/wwdt_top_test.sv */
/*
  Self-checking bench for the windowed watchdog.
  Assumes a 16-cycle tick, far above the sync delay, to keep runs short.
*/
`timescale 1ns/100ps
`default_nettype none
module wwdt_top_test;
  logic        clk = 0, arst_n = 0, tick = 0, dbg = 0;
  logic [7:0]  fuse = 8'h00, q, v;
  logic [31:0] wdata, rdata, seed = 32'h31;
  logic [3:0]  be;
  logic [1:0]  addr;
  logic        rd, wr, clr, unl, wreq, req;
  int          failures = 0, tests_run = 0, cyc = 0, n, k, t;

  always #25 clk = ~clk;
  always begin
    repeat (8) @(posedge clk);
    tick <= ~tick;
  end

  wwdt_top uut (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .TICK_CLOCK_IN(tick), .BOOT_FUSE_CONFIG_IN(fuse),
    .COUNTER_CLEAR_INSTR_IN(clr), .CHANGE_PROTECT_UNLOCK_IN(unl), .DEBUG_HALT_IN(dbg), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .SYS_RESET_REQ_OUT(req));
  wwdt_core_model core (.clk_in(clk), .rdata_in(rdata), .wait_in(wreq), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wdata_out(wdata), .be_out(be), .clr_out(clr), .unl_out(unl));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ticks(input logic [3:0] c);
    return (c == 4'h0 || c > 4'hB) ? 8192 : 8 << (c - 4'h1);
  endfunction

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi);
    cmp(nm, 8'h01, {7'h0, n >= lo && n <= hi});
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic boot(input logic [7:0] f);
    arst_n <= 1'b0;
    fuse   <= f;
    dbg    <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic tk(input int m);
    repeat (m * 16) @(posedge clk);
  endtask
  task automatic fire(input int lim);
    for (n = 0; n < lim && req !== 1'b1; n++) @(posedge clk);
  endtask
  task automatic rdq(input logic [1:0] a);
    core.xfer(1'b0, a, 8'h00, q);
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    for (k = 0; k < 4; k++) begin
      v = 8'(rnd());
      boot(v);
      rdq(2'h0); cmp("ctrl_boot", v, q);
      rdq(2'h1); cmp("lock_boot", {v[3:0] != 4'h0, 7'h0}, q);
    end
    boot(8'h30);
    core.clear();
    fire(20 * 16); cmp("off_quiet", 8'h00, {7'h0, req});
    for (k = 0; k < 3; k++) begin
      t = ticks(4'h1 << k);
      boot(8'h01 << k);
      repeat (6) begin
        tk(1 + rnd() % (t - 3));
        core.clear();
      end
      fire(3 * 16 * t); rng("fire_normal", (t - 1) * 16, (t + 1) * 16 + 12);
      tk(3); cmp("req_held", 8'h01, {7'h0, req});
    end
    boot(8'h22);
    fire(40 * 16); rng("first_norm", 14 * 16, 17 * 16);
    boot(8'h22);
    tk(10); cmp("win_idle", 8'h00, {7'h0, req});
    core.clear();
    tk(4); cmp("first_clr", 8'h00, {7'h0, req});
    tk(16);
    core.clear();
    tk(4); cmp("open_ok", 8'h00, {7'h0, req});
    core.clear();
    fire(48); rng("early", 0, 40);
    boot(8'h12);
    core.clear();
    fire(40 * 16); rng("late", 23 * 16, 25 * 16 + 12);
    boot(8'h00);
    core.xfer(1'b1, 2'h0, 8'h11, q);
    rdq(2'h0); cmp("ctrl_noul", 8'h00, q);
    core.be_out <= 4'hE;
    core.prot(2'h0, 8'h12);
    core.be_out <= 4'h1;
    rdq(2'h0); cmp("ctrl_be", 8'h00, q);
    core.prot(2'h0, 8'h12);
    rdq(2'h1); cmp("pend_set", 8'h01, q);
    rdq(2'h0); cmp("ctrl_ul", 8'h12, q);
    tk(3);
    rdq(2'h1); cmp("pend_clr", 8'h00, q);
    core.clear();
    fire(40 * 16); rng("new_cfg", 23 * 16, 25 * 16 + 12);
    boot(8'h00);
    core.prot(2'h1, 8'h80);
    core.prot(2'h0, 8'h05);
    rdq(2'h0); cmp("ctrl_locked", 8'h00, q);
    core.prot(2'h1, 8'h00);
    rdq(2'h1); cmp("lock_sticky", 8'h80, q);
    core.xfer(1'b1, 2'h3, 8'hFF, q);
    rdq(2'h2); cmp("unmapped", 8'h00, q);
    @(posedge clk) dbg <= 1'b1;
    core.prot(2'h1, 8'h00);
    rdq(2'h1); cmp("lock_dbg", 8'h00, q);
    repeat (3) begin
      v = 8'(rnd());
      core.prot(2'h0, v);
      rdq(2'h0); cmp("ctrl_rand", v, q);
    end
    boot(8'h11);
    core.clear();
    @(posedge clk) dbg <= 1'b1;
    fire(20 * 16); cmp("dbg_hold", 8'h00, {7'h0, req});
    @(posedge clk) dbg <= 1'b0;
    fire(30 * 16); rng("dbg_resume", 6 * 16, 9 * 16 + 12);
    conclude();
  end
endmodule
`default_nettype wire
